// File: dv/cpu_bus_model.sv
// Byte bus master standing in for the CPU core, with vector acknowledge.
`timescale 1ns/1ps
module cpu_bus_model
(
   input wire logic clk,
   output logic [3:0] reg_sel,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic [3:0] irq_lines,
   output logic [3:0] irq_ack
);
   logic auto_ack;
   initial
   begin
      reg_sel = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      wdata = 8'h00;
      irq_ack = 4'h0;
      auto_ack = 1'b0;
   end
   // One acknowledge pulse per raised request, as a vector would run.
   always @(negedge clk)
      irq_ack <= irq_lines & ~irq_ack & {4{auto_ack}};
   // Released data is inverted so a stale value never looks valid.
   task automatic wr(input logic [3:0] sel, input logic [7:0] data);
      @(negedge clk);
      reg_sel = sel;
      wdata = data;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      wdata = ~data;
   endtask
   task automatic rd(input logic [3:0] sel, output logic [7:0] data);
      @(negedge clk);
      reg_sel = sel;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      data = rdata;
   endtask
endmodule // cpu_bus_model

// File: dv/pwm_timer_core_properties.sv
// Concurrent checks on the ports of the timer register core.
`timescale 1ns/1ps
`include "pwm_timer_map.vh"
module pwm_timer_core_properties
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic six_output_pwm,
   input wire logic global_irq_enable,
   input wire logic [5:0] port_pin_values,
   input wire logic [5:0] compare_pins,
   input wire logic irq_match_d,
   input wire logic irq_match_a,
   input wire logic irq_match_b,
   input wire logic irq_overflow,
   input wire logic [7:0] irq_vector
);
   logic [7:0] ctl;
   logic [7:0] msk;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Shadows of control E and mask, loaded on the same edge as the core.
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         ctl <= 8'h00;
         msk <= 8'h00;
      end
      else if (reg_wr && reg_sel == `SEL_CONTROL_E)
         ctl <= wdata;
      else if (reg_wr && reg_sel == `SEL_MASK)
         msk <= wdata;
   end
   sequence s_stage_read;
      reg_rd && reg_sel == `SEL_STAGING;
   endsequence
   sequence s_mask_read;
      reg_rd && reg_sel == `SEL_MASK;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // Reset must silence read data, pins and vector, so this one runs during reset too.
   chk_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
      !reset_n |=> rdata == 8'h00 && compare_pins == 6'h00
      && irq_vector == 8'h00)
      else $error("outputs not cleared by reset");
   chk_stage_zeros: assert property (s_stage_read |=> rdata[7:3] == 5'h00)
      else $error("staging upper bits not zero");
   chk_mask_read: assert property (s_mask_read |=> rdata == (msk & 8'hE4))
      else $error("mask readback wrong");
   chk_unmapped_zero: assert property (reg_rd && reg_sel > 4'h8 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_holds: assert property (!reg_rd |=> $stable(rdata))
      else $error("read data moved without a read");
   chk_irq_d_gate: assert property (irq_match_d |-> $past(msk[7] && global_irq_enable))
      else $error("match d request without enables");
   chk_irq_a_gate: assert property (irq_match_a |-> $past(msk[6] && global_irq_enable))
      else $error("match a request without enables");
   chk_irq_b_gate: assert property (irq_match_b |-> $past(msk[5] && global_irq_enable))
      else $error("match b request without enables");
   chk_irq_ovf_gate: assert property (irq_overflow |-> $past(msk[2] && global_irq_enable))
      else $error("overflow request without enables");
   // Disconnected pins must show the port values of the previous cycle.
   chk_port_passthru: assert property ($past(six_output_pwm && reset_n) |->
      ((compare_pins ^ $past(port_pin_values)) & ~$past(ctl[5:0])) == 6'h00)
      else $error("port value not on disconnected pin");
   chk_pair_invert: assert property ($past(six_output_pwm && reset_n && ctl[1:0] == 2'b11)
      |-> compare_pins[1] != compare_pins[0])
      else $error("pin pair a not complementary");
endmodule // pwm_timer_core_properties
bind pwm_timer_core pwm_timer_core_properties u_props (.clk(clk),
   .reset_n(reset_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .wdata(wdata), .rdata(rdata), .six_output_pwm(six_output_pwm),
   .global_irq_enable(global_irq_enable), .port_pin_values(port_pin_values),
   .compare_pins(compare_pins), .irq_match_d(irq_match_d),
   .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
   .irq_overflow(irq_overflow), .irq_vector(irq_vector));

// File: dv/pwm_timer_core_tb_top.sv
// Self-checking bench for the timer register core.
`timescale 1ns/1ps
`include "pwm_timer_map.vh"
module pwm_timer_core_tb_top;
   logic clk, reset_n, reg_wr, reg_rd, count_tick, dual_slope;
   logic six_output_pwm, async_mode, global_irq_enable;
   logic irq_match_d, irq_match_a, irq_match_b, irq_overflow;
   logic [3:0] reg_sel, irq_ack;
   logic [7:0] wdata, rdata, irq_vector, rd_val;
   logic [5:0] port_pin_values, compare_pins;
   int num_errors = 0, compares = 0, cycles = 0, i;
   logic [7:0] mbit [4] = '{8'h40, 8'h20, 8'h80, 8'h04};
   logic [7:0] vec [4] = '{8'h03, 8'h09, 8'h10, 8'h04};
   logic [7:0] lbit [4] = '{8'h04, 8'h02, 8'h08, 8'h01};
   // The last slot restarts the counter below the period rather than
   // moving the period under it, so the overflow comes within a few ticks.
   logic [3:0] csel [4] = '{4'h3, 4'h4, 4'h6, 4'h1};
   wire [7:0] req_lines = {4'h0, irq_match_d, irq_match_a, irq_match_b,
      irq_overflow};
   pwm_timer_core u_dut (.clk(clk), .reset_n(reset_n), .reg_sel(reg_sel),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .wdata(wdata), .rdata(rdata),
      .count_tick(count_tick), .dual_slope(dual_slope),
      .six_output_pwm(six_output_pwm), .async_mode(async_mode),
      .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
      .port_pin_values(port_pin_values), .compare_pins(compare_pins),
      .irq_match_d(irq_match_d), .irq_match_a(irq_match_a),
      .irq_match_b(irq_match_b), .irq_overflow(irq_overflow),
      .irq_vector(irq_vector));
   cpu_bus_model u_cpu (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .wdata(wdata), .rdata(rdata),
      .irq_lines({irq_match_d, irq_match_a, irq_match_b, irq_overflow}),
      .irq_ack(irq_ack));
   ////////////////////////////////////////////////////////////////////////
   // A 40 ns clock.
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [3:0] sel, input logic [7:0] exp);
      u_cpu.rd(sel, rd_val);
      chk8(rd_val, exp);
   endtask
   // The wait is bounded; a missing vector shows up as a mismatch.
   task automatic wait_vec;
      for (int n = 0; n < 60 && irq_vector === 8'h00; n++)
         @(negedge clk);
   endtask
   task automatic results;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Cuts a hang short well past the expected run length.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         num_errors = num_errors + 1;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence of register accesses and expected values.
   initial
   begin
      reset_n = 1'b0;
      count_tick = 1'b0;
      dual_slope = 1'b0;
      six_output_pwm = 1'b0;
      async_mode = 1'b0;
      global_irq_enable = 1'b0;
      port_pin_values = 6'h2A;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      rdchk(`SEL_CONTROL_E, 8'h00);
      rdchk(`SEL_MASK, 8'h00);
      rdchk(`SEL_PERIOD_C, 8'hFF);
      rdchk(`SEL_STAGING, 8'h03);
      rdchk(4'h9, 8'h00);
      u_cpu.wr(`SEL_CONTROL_E, 8'h40);
      u_cpu.wr(`SEL_STAGING, 8'hFF);
      rdchk(`SEL_STAGING, 8'h07);
      u_cpu.wr(`SEL_CONTROL_E, 8'h00);
      u_cpu.wr(`SEL_MASK, 8'hFF);
      rdchk(`SEL_MASK, 8'hE4);
      u_cpu.wr(`SEL_STAGING, 8'h01);
      u_cpu.wr(`SEL_COUNTER, 8'h55);
      repeat (3) @(negedge clk);
      rdchk(`SEL_COUNTER, 8'h55);
      rdchk(`SEL_STAGING, 8'h01);
      async_mode = 1'b1;
      u_cpu.wr(`SEL_STAGING, 8'h02);
      u_cpu.wr(`SEL_COUNTER, 8'hAA);
      rdchk(`SEL_COUNTER, 8'hAA);
      rdchk(`SEL_STAGING, 8'h02);
      async_mode = 1'b0;
      u_cpu.wr(`SEL_STAGING, 8'h00);
      u_cpu.wr(`SEL_PERIOD_C, 8'h01);
      rdchk(`SEL_PERIOD_C, 8'h03);
      u_cpu.wr(`SEL_PERIOD_C, 8'h05);
      u_cpu.wr(`SEL_COUNTER, 8'h00);
      count_tick = 1'b1;
      six_output_pwm = 1'b1;
      repeat (3) @(negedge clk);
      chk8({2'b00, compare_pins}, 8'h2A);
      u_cpu.wr(`SEL_CONTROL_E, 8'h03);
      repeat (2) @(negedge clk);
      chk8({2'b00, compare_pins[5:2], 2'b00}, 8'h28);
      chk8({7'h00, compare_pins[1] ^ compare_pins[0]}, 8'h01);
      u_cpu.auto_ack = 1'b1;
      for (i = 0; i < 4; i++)
      begin
         global_irq_enable = 1'b0;
         u_cpu.wr(`SEL_MASK, mbit[i]);
         u_cpu.wr(csel[i], 8'h02);
         u_cpu.wr(`SEL_FLAGS, 8'hFF);
         global_irq_enable = 1'b1;
         wait_vec();
         chk8(irq_vector, vec[i]);
         chk8(req_lines, lbit[i]);
      end
      // A software write that lands on the compare value must stay silent.
      // Acknowledge is off so that a false flag would stay visible.
      u_cpu.auto_ack = 1'b0;
      count_tick = 1'b0;
      global_irq_enable = 1'b0;
      u_cpu.wr(`SEL_MASK, 8'h40);
      u_cpu.wr(`SEL_COMPARE_A, 8'h07);
      u_cpu.wr(`SEL_COUNTER, 8'h07);
      u_cpu.wr(`SEL_FLAGS, 8'hFF);
      global_irq_enable = 1'b1;
      repeat (10) @(negedge clk);
      chk8({7'h00, irq_match_a}, 8'h00);
      rdchk(`SEL_FLAGS, 8'h00);
      // Locked: the new compare value waits in the buffer until release.
      u_cpu.wr(`SEL_CONTROL_E, 8'h80);
      u_cpu.wr(`SEL_COMPARE_A, 8'h02);
      u_cpu.wr(`SEL_COUNTER, 8'h00);
      count_tick = 1'b1;
      u_cpu.wr(`SEL_FLAGS, 8'hFF);
      repeat (20) @(negedge clk);
      u_cpu.rd(`SEL_FLAGS, rd_val);
      chk8(rd_val & 8'h40, 8'h00);
      u_cpu.wr(`SEL_CONTROL_E, 8'h00);
      repeat (10) @(negedge clk);
      u_cpu.rd(`SEL_FLAGS, rd_val);
      chk8(rd_val & 8'h40, 8'h40);
      // Dual slope turns down above the period and flags on reaching zero;
      // single slope from above the period would not wrap for a long time.
      dual_slope = 1'b1;
      u_cpu.wr(`SEL_COUNTER, 8'h08);
      u_cpu.wr(`SEL_FLAGS, 8'hFF);
      repeat (15) @(negedge clk);
      u_cpu.rd(`SEL_FLAGS, rd_val);
      chk8(rd_val & 8'h04, 8'h04);
      // Enhanced mode: the eleventh bit travels through staging bit 2.
      u_cpu.wr(`SEL_CONTROL_E, 8'h40);
      u_cpu.wr(`SEL_STAGING, 8'h05);
      u_cpu.wr(`SEL_COMPARE_B, 8'h3C);
      u_cpu.wr(`SEL_STAGING, 8'h00);
      rdchk(`SEL_COMPARE_B, 8'h3C);
      rdchk(`SEL_STAGING, 8'h05);
      results();
   end
endmodule // pwm_timer_core_tb_top

// File: hdl/compare_channel.v
// One buffered compare channel with lock, enhanced edge bit and waveform.
`timescale 1ns/1ps
module compare_channel
#(
   parameter WIDTH = 10
)
(
   input wire clk,
   input wire reset_n,
   input wire load,
   input wire [WIDTH:0] load_value,
   input wire [WIDTH:0] reset_value,
   input wire update_lock,
   input wire enhanced,
   input wire counted,
   input wire [WIDTH-1:0] counter,
   output reg [WIDTH:0] buffer_value,
   output reg [WIDTH:0] active_value,
   output reg match,
   output reg wave
);

reg delayed_hit;
wire hit;

// A hit needs a counting step; a software load of the counter never hits.
assign hit = counted && (counter == active_value[WIDTH:1]);

////////////////////////////////////////////////////////////////////////
// Buffer takes every write; active copy follows only while unlocked.
always @(posedge clk)
begin
   if (!reset_n)
   begin
      buffer_value <= reset_value;
      active_value <= reset_value;
   end
   else
   begin
      if (load)
         buffer_value <= load_value;
      if (!update_lock)
         active_value <= buffer_value;
   end
end

////////////////////////////////////////////////////////////////////////
// Enhanced low bit moves the event one clock later, a half timer step.
always @(posedge clk)
begin
   if (!reset_n)
   begin
      delayed_hit <= 1'b0;
      match <= 1'b0;
      wave <= 1'b0;
   end
   else
   begin
      delayed_hit <= hit && enhanced && active_value[0];
      match <= (hit && !(enhanced && active_value[0])) || delayed_hit;
      if (counted && counter == {WIDTH{1'b0}})
         wave <= 1'b1;
      else if ((hit && !(enhanced && active_value[0])) || delayed_hit)
         wave <= 1'b0;
   end
end

endmodule // compare_channel

// File: hdl/pwm_timer_core.v
// Register core of the 10-bit up/down high-speed PWM timer.
// What this block does
// - Lock set buffers compare writes; release moves them to active copies.
// - Enhanced mode adds compare low bit choosing the signalling clock edge.
// - Six-output mode: override enables connect pins, else port values show.
// - Enable bits 0..5 map to A, not A, B, not B, D, not D.
// - Counter is 10-bit up/down, readable and writable over byte bus.
// - Counter write takes effect two edges later sync, one edge async.
// - Any software counter write restarts counting upward.
// - One staging register holds bits 9:8 for all 10-bit accesses.
// - Staging bit 2 carries the eleventh bit in enhanced mode.
// - Staging bits 7:3 always read as zero.
// - Match only when counting reaches compare, never on a software write.
// - Match A, B, D sets its flag one synchronisation cycle later.
// - Match against period register C clears the counter in single slope; dual slope turns down there.
// - Period writes below three store three.
// - Matches D, A, B request own vectors when enabled globally too.
// - Overflow requests its vector when enabled and globally enabled.
// - Mask bits: D at 7, A at 6, B at 5, overflow at 2.
// - Overflow flag at top wrap single slope, at bottom dual slope.
// - Flags clear on vector acknowledge or one cycle after writing one.
`timescale 1ns/1ps
`include "pwm_timer_map.vh"
module pwm_timer_core
(
   input wire clk,
   input wire reset_n,
   input wire [3:0] reg_sel,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] wdata,
   output reg [7:0] rdata,
   input wire count_tick,
   input wire dual_slope,
   input wire six_output_pwm,
   input wire async_mode,
   input wire global_irq_enable,
   input wire [3:0] irq_ack,
   input wire [5:0] port_pin_values,
   output reg [5:0] compare_pins,
   output reg irq_match_d,
   output reg irq_match_a,
   output reg irq_match_b,
   output reg irq_overflow,
   output reg [7:0] irq_vector
);

reg [7:0] control_e;
reg [7:0] mask;
reg [2:0] staging;
reg [9:0] counter;
reg count_down;
reg counted;
reg wr_stage1;
reg wr_stage2;
reg [9:0] wr_value;
reg match_d_flag;
reg match_a_flag;
reg match_b_flag;
reg overflow_flag;
reg [7:0] clear_pending;
reg overflow_event;
reg [9:0] next_counter;
reg next_down;
reg next_overflow;
reg [10:0] next_compare;
reg [10:0] next_period;
reg [9:0] period_raw;

wire update_lock;
wire enhanced;
wire wr_a;
wire wr_b;
wire wr_c;
wire wr_d;
wire wr_apply;
wire [10:0] buf_a;
wire [10:0] buf_b;
wire [10:0] buf_c;
wire [10:0] buf_d;
wire [10:0] act_c;
wire [10:0] act_a_unused;
wire [10:0] act_b_unused;
wire [10:0] act_d_unused;
wire match_a;
wire match_b;
wire match_d;
wire wave_a;
wire wave_b;
wire wave_d;
wire [9:0] top;
wire [5:0] waves;
wire [3:0] pending_irq;

assign update_lock = control_e[`BIT_UPDATE_LOCK];
assign enhanced = control_e[`BIT_ENHANCED];
assign wr_a = reg_wr && reg_sel == {1'b0, `SEL_COMPARE_A};
assign wr_b = reg_wr && reg_sel == {1'b0, `SEL_COMPARE_B};
assign wr_c = reg_wr && reg_sel == {1'b0, `SEL_PERIOD_C};
assign wr_d = reg_wr && reg_sel == {1'b0, `SEL_COMPARE_D};
assign top = act_c[10:1];

////////////////////////////////////////////////////////////////////////
// Low-byte write joins the staged high bits; enhanced keeps the 11th bit.
always @*
begin
   if (enhanced)
      next_compare = {staging, wdata};
   else
      next_compare = {staging[1:0], wdata, 1'b0};
   period_raw = {staging[1:0], wdata};
   if (period_raw < `PERIOD_MIN)
      next_period = {`PERIOD_MIN, 1'b0};
   else
      next_period = {period_raw, 1'b0};
end

////////////////////////////////////////////////////////////////////////
// Four identical channels; C only supplies the period limit.
compare_channel #(.WIDTH(10)) chan_a
(
   .clk(clk), .reset_n(reset_n), .load(wr_a), .load_value(next_compare),
   .reset_value(11'h000), .update_lock(update_lock), .enhanced(enhanced),
   .counted(counted), .counter(counter), .buffer_value(buf_a),
   .active_value(act_a_unused), .match(match_a), .wave(wave_a)
);
compare_channel #(.WIDTH(10)) chan_b
(
   .clk(clk), .reset_n(reset_n), .load(wr_b), .load_value(next_compare),
   .reset_value(11'h000), .update_lock(update_lock), .enhanced(enhanced),
   .counted(counted), .counter(counter), .buffer_value(buf_b),
   .active_value(act_b_unused), .match(match_b), .wave(wave_b)
);
compare_channel #(.WIDTH(10)) chan_c
(
   .clk(clk), .reset_n(reset_n), .load(wr_c), .load_value(next_period),
   .reset_value(`PERIOD_RESET), .update_lock(update_lock),
   .enhanced(1'b0), .counted(counted), .counter(counter),
   .buffer_value(buf_c), .active_value(act_c), .match(), .wave()
);
compare_channel #(.WIDTH(10)) chan_d
(
   .clk(clk), .reset_n(reset_n), .load(wr_d), .load_value(next_compare),
   .reset_value(11'h000), .update_lock(update_lock), .enhanced(enhanced),
   .counted(counted), .counter(counter), .buffer_value(buf_d),
   .active_value(act_d_unused), .match(match_d), .wave(wave_d)
);

////////////////////////////////////////////////////////////////////////
// Counter writes pass a synchronisation stage; async mode skips one.
assign wr_apply = (wr_stage1 && async_mode) || wr_stage2;

always @(posedge clk)
begin
   if (!reset_n)
   begin
      wr_stage1 <= 1'b0;
      wr_stage2 <= 1'b0;
      wr_value <= 10'h000;
   end
   else
   begin
      wr_stage1 <= reg_wr && reg_sel == {1'b0, `SEL_COUNTER};
      wr_stage2 <= wr_stage1 && !async_mode;
      if (reg_wr && reg_sel == {1'b0, `SEL_COUNTER})
         wr_value <= {staging[1:0], wdata};
   end
end

////////////////////////////////////////////////////////////////////////
// Next counter value: clear at period in single slope, turn in dual.
always @*
begin
   next_counter = counter;
   next_down = count_down;
   next_overflow = 1'b0;
   if (wr_apply)
   begin
      next_counter = wr_value;
      next_down = 1'b0;
   end
   else if (count_tick)
   begin
      if (!dual_slope)
      begin
         if (counter == top)
         begin
            next_counter = 10'h000;
            next_overflow = 1'b1;
         end
         else
            next_counter = counter + 10'h001;
      end
      else if (!count_down)
      begin
         if (counter >= top)
         begin
            next_down = 1'b1;
            next_counter = counter - 10'h001;
         end
         else
            next_counter = counter + 10'h001;
      end
      else
      begin
         if (counter == 10'h000)
         begin
            next_down = 1'b0;
            next_counter = 10'h001;
         end
         else
         begin
            next_counter = counter - 10'h001;
            next_overflow = counter == 10'h001;
         end
      end
   end
end

// Counted marks a step taken by the counter itself, not by software.
always @(posedge clk)
begin
   if (!reset_n)
   begin
      counter <= 10'h000;
      count_down <= 1'b0;
      counted <= 1'b0;
      overflow_event <= 1'b0;
   end
   else
   begin
      counter <= next_counter;
      count_down <= next_down;
      counted <= count_tick && !wr_apply;
      overflow_event <= next_overflow;
   end
end

////////////////////////////////////////////////////////////////////////
// Control, mask and staging writes; a low-byte read latches high bits.
always @(posedge clk)
begin
   if (!reset_n)
   begin
      control_e <= `CONTROL_E_RESET;
      mask <= `MASK_RESET;
      staging <= 3'h0;
   end
   else
   begin
      if (reg_wr && reg_sel == {1'b0, `SEL_CONTROL_E})
         control_e <= wdata;
      if (reg_wr && reg_sel == {1'b0, `SEL_MASK})
         mask <= wdata & 8'hE4;
      if (reg_wr && reg_sel == {1'b0, `SEL_STAGING})
         staging <= wdata[2:0];
      else if (reg_rd)
      begin
         case (reg_sel)
            {1'b0, `SEL_COUNTER}: staging <= {1'b0, counter[9:8]};
            {1'b0, `SEL_COMPARE_A}: staging <= enhanced ? buf_a[10:8]
               : {1'b0, buf_a[10:9]};
            {1'b0, `SEL_COMPARE_B}: staging <= enhanced ? buf_b[10:8]
               : {1'b0, buf_b[10:9]};
            {1'b0, `SEL_PERIOD_C}: staging <= {1'b0, buf_c[10:9]};
            {1'b0, `SEL_COMPARE_D}: staging <= enhanced ? buf_d[10:8]
               : {1'b0, buf_d[10:9]};
            default: staging <= staging;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Read data is registered; byte reads need no staging access.
always @(posedge clk)
begin
   if (!reset_n)
      rdata <= 8'h00;
   else if (reg_rd)
   begin
      case (reg_sel)
         {1'b0, `SEL_CONTROL_E}: rdata <= control_e;
         {1'b0, `SEL_COUNTER}: rdata <= counter[7:0];
         {1'b0, `SEL_STAGING}: rdata <= {5'h00, staging};
         {1'b0, `SEL_COMPARE_A}: rdata <= enhanced ? buf_a[7:0] : buf_a[8:1];
         {1'b0, `SEL_COMPARE_B}: rdata <= enhanced ? buf_b[7:0] : buf_b[8:1];
         {1'b0, `SEL_PERIOD_C}: rdata <= buf_c[8:1];
         {1'b0, `SEL_COMPARE_D}: rdata <= enhanced ? buf_d[7:0] : buf_d[8:1];
         {1'b0, `SEL_MASK}: rdata <= mask;
         `SEL_FLAGS: rdata <= {match_d_flag, match_a_flag, match_b_flag,
            2'b00, overflow_flag, 2'b00};
         default: rdata <= 8'h00;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// Flags: a write of one clears a cycle later; a new event wins the clear.
always @(posedge clk)
begin
   if (!reset_n)
   begin
      clear_pending <= 8'h00;
      match_d_flag <= 1'b0;
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
      overflow_flag <= 1'b0;
   end
   else
   begin
      clear_pending <= (reg_wr && reg_sel == `SEL_FLAGS) ? wdata : 8'h00;
      match_d_flag <= match_d || (match_d_flag && !irq_ack[3]
         && !clear_pending[`BIT_MATCH_D]);
      match_a_flag <= match_a || (match_a_flag && !irq_ack[2]
         && !clear_pending[`BIT_MATCH_A]);
      match_b_flag <= match_b || (match_b_flag && !irq_ack[1]
         && !clear_pending[`BIT_MATCH_B]);
      overflow_flag <= overflow_event || (overflow_flag && !irq_ack[0]
         && !clear_pending[`BIT_OVERFLOW]);
   end
end

////////////////////////////////////////////////////////////////////////
// Requests and the vector of the highest-priority pending one.
assign pending_irq = {match_d_flag && mask[`BIT_MATCH_D],
   match_a_flag && mask[`BIT_MATCH_A], match_b_flag && mask[`BIT_MATCH_B],
   overflow_flag && mask[`BIT_OVERFLOW]} & {4{global_irq_enable}};

always @(posedge clk)
begin
   if (!reset_n)
   begin
      irq_match_d <= 1'b0;
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
      irq_overflow <= 1'b0;
      irq_vector <= 8'h00;
   end
   else
   begin
      irq_match_d <= pending_irq[3];
      irq_match_a <= pending_irq[2];
      irq_match_b <= pending_irq[1];
      irq_overflow <= pending_irq[0];
      // Lowest vector address has the highest priority.
      if (pending_irq[2])
         irq_vector <= `VECTOR_MATCH_A;
      else if (pending_irq[0])
         irq_vector <= `VECTOR_OVERFLOW;
      else if (pending_irq[1])
         irq_vector <= `VECTOR_MATCH_B;
      else if (pending_irq[3])
         irq_vector <= `VECTOR_MATCH_D;
      else
         irq_vector <= 8'h00;
   end
end

////////////////////////////////////////////////////////////////////////
// Pin mux reacts the next edge after an enable change, with no waiting
// for a period boundary.
assign waves = {~wave_d, wave_d, ~wave_b, wave_b, ~wave_a, wave_a};

always @(posedge clk)
begin
   if (!reset_n)
      compare_pins <= 6'h00;
   else if (six_output_pwm)
      compare_pins <= (waves & control_e[5:0])
         | (port_pin_values & ~control_e[5:0]);
   else
      compare_pins <= (waves & 6'h15) | (port_pin_values & 6'h2A);
end

endmodule // pwm_timer_core

// File: hdl/pwm_timer_map.vh
// Register indices, field positions, reset values and vectors of the timer.
`ifndef PWM_TIMER_MAP_VH
`define PWM_TIMER_MAP_VH

// Register select codes on the CPU data bus port.
`define SEL_CONTROL_E 3'h0
`define SEL_COUNTER 3'h1
`define SEL_STAGING 3'h2
`define SEL_COMPARE_A 3'h3
`define SEL_COMPARE_B 3'h4
`define SEL_PERIOD_C 3'h5
`define SEL_COMPARE_D 3'h6
`define SEL_MASK 3'h7
// The flag register shares the control E code with the high select bit.
`define SEL_FLAGS 4'h8

// Control register E fields.
`define BIT_UPDATE_LOCK 7
`define BIT_ENHANCED 6
`define CONTROL_E_RESET 8'h00

// Interrupt mask and flag bit positions.
`define BIT_MATCH_D 7
`define BIT_MATCH_A 6
`define BIT_MATCH_B 5
`define BIT_OVERFLOW 2
`define MASK_RESET 8'h00

// Smallest value the period register holds.
`define PERIOD_MIN 10'h003
// Reset value of the period register, in the stored 11-bit layout.
`define PERIOD_RESET 11'h7FE

// Interrupt vector addresses.
`define VECTOR_MATCH_D 8'h10
`define VECTOR_MATCH_A 8'h03
`define VECTOR_MATCH_B 8'h09
`define VECTOR_OVERFLOW 8'h04

`endif
